// *** verilog/iop_pkg.sv ***
/*
  Constants for the I/O port bank: register indices, field positions,
  reset values and the LCD port-mask thresholds.
  Assumes a 32-bit classic Wishbone bus; byte address = index * 4.
*/
package iop_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned IOP_PORTS = 6;
  localparam int unsigned IOP_PIN_PORTS = 5;
  localparam int unsigned IOP_GPINS = 4;

  // ==========================================================
  // Register indices
  localparam logic [5:0] IOP_IDX_A_PIN = 6'h00;
  localparam logic [5:0] IOP_IDX_A_DIR = 6'h01;
  localparam logic [5:0] IOP_IDX_A_OUT = 6'h02;
  localparam logic [5:0] IOP_IDX_B_PIN = 6'h03;
  localparam logic [5:0] IOP_IDX_B_DIR = 6'h04;
  localparam logic [5:0] IOP_IDX_B_OUT = 6'h05;
  localparam logic [5:0] IOP_IDX_C_PIN = 6'h06;
  localparam logic [5:0] IOP_IDX_C_DIR = 6'h07;
  localparam logic [5:0] IOP_IDX_C_OUT = 6'h08;
  localparam logic [5:0] IOP_IDX_D_PIN = 6'h09;
  localparam logic [5:0] IOP_IDX_D_DIR = 6'h0a;
  localparam logic [5:0] IOP_IDX_D_OUT = 6'h0b;
  localparam logic [5:0] IOP_IDX_E_PIN = 6'h0c;
  localparam logic [5:0] IOP_IDX_E_DIR = 6'h0d;
  localparam logic [5:0] IOP_IDX_E_OUT = 6'h0e;
  localparam logic [5:0] IOP_IDX_F_DIR = 6'h10;
  localparam logic [5:0] IOP_IDX_F_OUT = 6'h11;
  localparam logic [5:0] IOP_IDX_MCU = 6'h35;

  // ==========================================================
  // Control register fields
  localparam int unsigned IOP_MCU_DBG_DIS = 7;
  localparam int unsigned IOP_MCU_PULL_DIS = 4;
  localparam int unsigned IOP_MCU_VSEL = 1;
  localparam int unsigned IOP_MCU_VCE = 0;
  localparam logic [7:0] IOP_MCU_WMASK = 8'h93;

  // ==========================================================
  // Reset values
  localparam logic [7:0] IOP_DIR_RST = 8'h00;
  localparam logic [7:0] IOP_OUT_RST = 8'h00;
  localparam logic [7:0] IOP_PIN_RST = 8'h00;
  localparam logic [7:0] IOP_MCU_RST = 8'h00;

  // ==========================================================
  // LCD port-mask thresholds
  localparam logic [2:0] IOP_LCD_MASK_G3 = 3'h6;
  localparam logic [2:0] IOP_LCD_MASK_G10 = 3'h0;

  // ==========================================================
  // Access kinds
  typedef enum {
    IOP_ACC_NONE,
    IOP_ACC_PIN,
    IOP_ACC_DIR,
    IOP_ACC_OUT,
    IOP_ACC_MCU
  } iop_acc_type;

endpackage

// *** verilog/iop_pin_cell.sv ***
/*
  Pin control for one 8-bit port: register-derived controls with
  per-pin override enables and values for pull-up, direction and
  digital input enable.
  Assumes override signals arrive from the alternate-function owner.
*/
module iop_pin_cell
  import iop_pkg::*;
(
  // Register side
  input wire logic [7:0] dir_i,
  input wire logic [7:0] out_i,
  input wire logic pull_dis_i,
  // Overrides
  input wire logic [7:0] pu_oe_i,
  input wire logic [7:0] pu_ov_i,
  input wire logic [7:0] dd_oe_i,
  input wire logic [7:0] dd_ov_i,
  input wire logic [7:0] ie_oe_i,
  input wire logic [7:0] ie_ov_i,
  // Pad side
  output logic [7:0] pin_out_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] pullup_o,
  output logic [7:0] in_en_o
);

  // ==========================================================
  // Control mux
  logic [7:0] reg_pull;

  always_comb
  begin
    // Pull-up only for input with data one
    reg_pull = ~dir_i & out_i & {8{~pull_dis_i}}; // [R12] [R4]
    // Disable wins even over an override value of one
    pullup_o = ((pu_oe_i & pu_ov_i) | (~pu_oe_i & reg_pull))
               & {8{~pull_dis_i}}; // [R11] [R4]
    pin_oe_o = (dd_oe_i & dd_ov_i) | (~dd_oe_i & dir_i); // [R11]
    in_en_o = (ie_oe_i & ie_ov_i) | ~ie_oe_i; // [R11]
    // Value and toggle overrides are not wired at all
    pin_out_o = out_i; // [R3]
  end

endmodule

// *** verilog/iop_port_bank.sv ***
/*
  I/O port bank: ports A to F with output data and direction registers,
  input pin registers on A to E, global control register and the LCD
  overrides on port G pins 3 to 0, behind a classic Wishbone slave.
  Assumes pins synchronous to clk_i; port G registers live elsewhere
  and feed their direction and data bits in.
*/
// Contract
// (R1) Pin G3 is overridden only with the LCD on and mask above 6; pin G2 whenever the LCD is on.
// (R2) Pins G1 and G0 are overridden while the LCD is on and the mask is above 0.
// (R3) Overridden G pins get pull-up off, input direction, input disabled; no value override.
// (R4) The global pull-up disable bit keeps every pull-up off.
// (R5) Control register holds bits 7, 4, 1, 0; bits 6, 5, 3, 2 read zero; resets to zero.
// (R6) Each port has an 8-bit read/write output data register that resets to zero.
// (R7) Each port has an 8-bit read/write direction register that resets to zero (inputs).
// (R8) Each of ports A to E has an 8-bit input pin register that follows the pins.
// (R9) Ports A to E take three addresses each: pins, direction, data, from index 0x00.
// (R10) Port F has direction at index 0x10 and data at 0x11.
// (R11) An asserted override enable replaces the register-derived control with its value.
// (R12) A pull-up is on only for direction zero, data one, no disable, no override.
module iop_port_bank
  import iop_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Ports A to F pads
  input wire logic [47:0] port_pin_i,
  output logic [47:0] port_out_o,
  output logic [47:0] port_oe_o,
  output logic [47:0] port_pullup_o,
  output logic [47:0] port_in_en_o,
  // LCD driver state
  input wire logic lcd_driver_enable_i,
  input wire logic [2:0] lcd_port_mask_i,
  // Port G pins 3 to 0
  input wire logic [3:0] portg_dir_i,
  input wire logic [3:0] portg_out_i,
  output logic [3:0] portg_out_o,
  output logic [3:0] portg_oe_o,
  output logic [3:0] portg_pullup_o,
  output logic [3:0] portg_in_en_o,
  // Control register fields
  output logic debug_interface_disable_o,
  output logic vector_table_select_o,
  output logic vector_change_enable_o
);

  // ==========================================================
  // Decode helpers
  function automatic iop_acc_type acc_kind(input logic [5:0] idx);
    iop_acc_type k;
    k = IOP_ACC_NONE;
    case (idx)
      IOP_IDX_A_PIN, IOP_IDX_B_PIN, IOP_IDX_C_PIN,
      IOP_IDX_D_PIN, IOP_IDX_E_PIN: k = IOP_ACC_PIN; // [R9]
      IOP_IDX_A_DIR, IOP_IDX_B_DIR, IOP_IDX_C_DIR,
      IOP_IDX_D_DIR, IOP_IDX_E_DIR: k = IOP_ACC_DIR; // [R9]
      IOP_IDX_F_DIR: k = IOP_ACC_DIR; // [R10]
      IOP_IDX_A_OUT, IOP_IDX_B_OUT, IOP_IDX_C_OUT,
      IOP_IDX_D_OUT, IOP_IDX_E_OUT: k = IOP_ACC_OUT; // [R9]
      IOP_IDX_F_OUT: k = IOP_ACC_OUT; // [R10]
      IOP_IDX_MCU: k = IOP_ACC_MCU;
      default: k = IOP_ACC_NONE;
    endcase
    return k;
  endfunction

  function automatic logic [2:0] acc_port(input logic [5:0] idx);
    logic [2:0] p;
    p = 3'h0;
    case (idx)
      IOP_IDX_A_PIN, IOP_IDX_A_DIR, IOP_IDX_A_OUT: p = 3'h0;
      IOP_IDX_B_PIN, IOP_IDX_B_DIR, IOP_IDX_B_OUT: p = 3'h1;
      IOP_IDX_C_PIN, IOP_IDX_C_DIR, IOP_IDX_C_OUT: p = 3'h2;
      IOP_IDX_D_PIN, IOP_IDX_D_DIR, IOP_IDX_D_OUT: p = 3'h3;
      IOP_IDX_E_PIN, IOP_IDX_E_DIR, IOP_IDX_E_OUT: p = 3'h4;
      IOP_IDX_F_DIR, IOP_IDX_F_OUT: p = 3'h5;
      default: p = 3'h0;
    endcase
    return p;
  endfunction

  // ==========================================================
  // State
  logic [IOP_PORTS-1:0][7:0] dir_r;
  logic [IOP_PORTS-1:0][7:0] dir_nxt;
  logic [IOP_PORTS-1:0][7:0] out_r;
  logic [IOP_PORTS-1:0][7:0] out_nxt;
  logic [IOP_PIN_PORTS-1:0][7:0] pin_r;
  logic [IOP_PIN_PORTS-1:0][7:0] pin_nxt;
  logic [7:0] mcu_r;
  logic [7:0] mcu_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;

  // ==========================================================
  // Bus decode
  logic req;
  logic wr;
  logic [5:0] idx;
  logic [2:0] prt;
  iop_acc_type kind;
  logic [7:0] rd_byte;
  logic pull_dis;

  // Ack drops the cycle after it rises, so one request is one beat
  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  // Byte lanes above zero hold no storage
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign idx = wb_adr_i[7:2];
  assign kind = acc_kind(idx);
  assign prt = acc_port(idx);
  assign pull_dis = mcu_r[IOP_MCU_PULL_DIS];

  always_comb
  begin
    rd_byte = 8'h00;
    case (kind)
      IOP_ACC_PIN: rd_byte = pin_r[prt]; // [R8]
      IOP_ACC_DIR: rd_byte = dir_r[prt]; // [R7]
      IOP_ACC_OUT: rd_byte = out_r[prt]; // [R6]
      IOP_ACC_MCU: rd_byte = mcu_r & IOP_MCU_WMASK; // [R5]
      default: rd_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // Register next state
  always_comb
  begin
    dir_nxt = dir_r;
    out_nxt = out_r;
    mcu_nxt = mcu_r;
    ack_nxt = req;
    rdat_nxt = rdat_r;
    // Input registers track the pads every cycle
    for (int i = 0; i < IOP_PIN_PORTS; i++)
    begin
      pin_nxt[i] = port_pin_i[i*8 +: 8]; // [R8]
    end
    if (req)
    begin
      rdat_nxt = {24'h000000, rd_byte};
    end
    if (wr)
    begin
      case (kind)
        IOP_ACC_DIR: dir_nxt[prt] = wb_dat_i[7:0]; // [R7]
        IOP_ACC_OUT: out_nxt[prt] = wb_dat_i[7:0]; // [R6]
        IOP_ACC_MCU: mcu_nxt = wb_dat_i[7:0] & IOP_MCU_WMASK; // [R5]
        // Pin registers follow the pads; a write there is dropped
        default: mcu_nxt = mcu_r;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dir_r <= {IOP_PORTS{IOP_DIR_RST}}; // [R7]
      out_r <= {IOP_PORTS{IOP_OUT_RST}}; // [R6]
      pin_r <= {IOP_PIN_PORTS{IOP_PIN_RST}};
      mcu_r <= IOP_MCU_RST; // [R5]
      ack_r <= 1'b0;
      rdat_r <= 32'h00000000;
    end
    else
    begin
      dir_r <= dir_nxt;
      out_r <= out_nxt;
      pin_r <= pin_nxt;
      mcu_r <= mcu_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign debug_interface_disable_o = mcu_r[IOP_MCU_DBG_DIS];
  assign vector_table_select_o = mcu_r[IOP_MCU_VSEL];
  assign vector_change_enable_o = mcu_r[IOP_MCU_VCE];

  // ==========================================================
  // Ports A to F pin control
  for (genvar g = 0; g < IOP_PORTS; g++)
  begin : g_port
    iop_pin_cell u_cell (
      .dir_i(dir_r[g]),
      .out_i(out_r[g]),
      .pull_dis_i(pull_dis),
      .pu_oe_i(8'h00),
      .pu_ov_i(8'h00),
      .dd_oe_i(8'h00),
      .dd_ov_i(8'h00),
      .ie_oe_i(8'h00),
      .ie_ov_i(8'h00),
      .pin_out_o(port_out_o[g*8 +: 8]),
      .pin_oe_o(port_oe_o[g*8 +: 8]),
      .pullup_o(port_pullup_o[g*8 +: 8]),
      .in_en_o(port_in_en_o[g*8 +: 8])
    );
  end

  // ==========================================================
  // Port G LCD overrides
  logic [3:0] lcd_ovr;
  logic [7:0] g_out;
  logic [7:0] g_oe;
  logic [7:0] g_pull;
  logic [7:0] g_ie;

  always_comb
  begin
    lcd_ovr[3] = lcd_driver_enable_i & (lcd_port_mask_i > IOP_LCD_MASK_G3); // [R1]
    lcd_ovr[2] = lcd_driver_enable_i; // [R1]
    lcd_ovr[1] = lcd_driver_enable_i & (lcd_port_mask_i > IOP_LCD_MASK_G10); // [R2]
    lcd_ovr[0] = lcd_driver_enable_i & (lcd_port_mask_i > IOP_LCD_MASK_G10); // [R2]
  end

  // Segment driver owns the pad, so all three values are zero
  iop_pin_cell u_gcell (
    .dir_i({4'h0, portg_dir_i}),
    .out_i({4'h0, portg_out_i}),
    .pull_dis_i(pull_dis),
    .pu_oe_i({4'h0, lcd_ovr}), // [R3]
    .pu_ov_i(8'h00),
    .dd_oe_i({4'h0, lcd_ovr}), // [R3]
    .dd_ov_i(8'h00),
    .ie_oe_i({4'h0, lcd_ovr}), // [R3]
    .ie_ov_i(8'h00),
    .pin_out_o(g_out),
    .pin_oe_o(g_oe),
    .pullup_o(g_pull),
    .in_en_o(g_ie)
  );

  assign portg_out_o = g_out[3:0];
  assign portg_oe_o = g_oe[3:0];
  assign portg_pullup_o = g_pull[3:0];
  assign portg_in_en_o = g_ie[3:0];

endmodule

// *** tb/iop_pad_model.sv ***
/*
  Pad model for ports A to F: drives the pad levels back to the bank.
  Assumes one clock; a pad with no driver and no pull-up floats.
*/
module iop_pad_model
(
  // Clock
  input wire logic clk_i,
  // Bank side
  input wire logic [47:0] out_i,
  input wire logic [47:0] oe_i,
  input wire logic [47:0] pullup_i,
  output logic [47:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================
  // Floating pads toggle so no stale level reads as valid
  logic [47:0] float_r = 48'h5555_5555_5555;
  always_ff @(posedge clk_i)
    float_r <= ~float_r;
  assign pin_o = (oe_i & out_i) | (~oe_i & (pullup_i | float_r));
endmodule

// *** tb/iop_port_bank_asserts.sv ***
/*
  Checker for the port bank: pad controls, port G overrides, bus answer.
  Assumes binding to the bank's top ports; one clock domain.
*/
module iop_port_bank_asserts
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Pads
  input wire logic [47:0] port_out_o,
  input wire logic [47:0] port_oe_o,
  input wire logic [47:0] port_pullup_o,
  // Port G
  input wire logic lcd_driver_enable_i,
  input wire logic [2:0] lcd_port_mask_i,
  input wire logic [3:0] portg_dir_i,
  input wire logic [3:0] portg_out_i,
  input wire logic [3:0] portg_out_o,
  input wire logic [3:0] portg_oe_o,
  input wire logic [3:0] portg_pullup_o,
  input wire logic [3:0] portg_in_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================
  // Helpers
  logic g3_on;
  logic g10_on;
  logic take;
  assign g3_on = lcd_driver_enable_i && lcd_port_mask_i > 3'h6;
  assign g10_on = lcd_driver_enable_i && lcd_port_mask_i > 3'h0;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_g3_forced:
    assert property (g3_on |-> !portg_in_en_o[3] && !portg_oe_o[3] && !portg_pullup_o[3])
    else $error("g3 not forced");
  a_g3_free:
    assert property (!g3_on |-> portg_in_en_o[3] && portg_oe_o[3] == portg_dir_i[3])
    else $error("g3 wrongly forced");
  a_g2_follow:
    assert property (portg_in_en_o[2] == !lcd_driver_enable_i) else $error("g2 override");
  a_g10_follow:
    assert property (portg_in_en_o[1:0] == {2{!g10_on}}) else $error("g1 g0 override");
  a_g_no_value:
    assert property (portg_out_o == portg_out_i) else $error("g value overridden");
  a_pullup_gate:
    assert property ((port_pullup_o & (port_oe_o | ~port_out_o)) == 48'h0)
    else $error("pull-up on wrong pin");
  a_ack_answer:
    assert property (take |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing");
  a_out_write:
    assert property (take && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h08
      |=> port_out_o[7:0] == $past(wb_dat_i[7:0])) else $error("port a data lost");
  a_reset_clear:
    assert property ($past(rst_i) |-> port_oe_o == 48'h0 && port_out_o == 48'h0)
    else $error("not cleared by reset");
endmodule

// *** tb/iop_port_bank_bench.sv ***
/*
  Bench for the port bank: bus tasks, one task per scenario.
  Assumes the pad model closes the pad loop; port G bits driven here.
*/
module iop_port_bank_bench import iop_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, lcd_driver_enable_i;
  logic debug_interface_disable_o, vector_table_select_o, vector_change_enable_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, portg_dir_i, portg_out_i, portg_out_o;
  logic [3:0] portg_oe_o, portg_pullup_o, portg_in_en_o, act;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [47:0] port_pin_i, port_out_o, port_oe_o, port_pullup_o, port_in_en_o;
  logic [2:0] lcd_port_mask_i;
  logic [5:0] tbl [12] = '{6'h01, 6'h02, 6'h04, 6'h05, 6'h07, 6'h08, 6'h0a, 6'h0b,
    6'h0d, 6'h0e, 6'h10, 6'h11};
  int fails, samples_checked;
  iop_port_bank iop_port_bank_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .port_pin_i, .port_out_o, .port_oe_o,
    .port_pullup_o, .port_in_en_o, .lcd_driver_enable_i, .lcd_port_mask_i, .portg_dir_i,
    .portg_out_i, .portg_out_o, .portg_oe_o, .portg_pullup_o, .portg_in_en_o,
    .debug_interface_disable_o, .vector_table_select_o, .vector_change_enable_o);
  iop_pad_model iop_pad_model_i (.clk_i, .out_i(port_out_o), .oe_i(port_oe_o),
    .pullup_i(port_pullup_o), .pin_o(port_pin_i));
  // ========================================
  // Shared tasks
  task chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task xfer(input logic w, input logic [5:0] idx, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    if (wb_ack_o !== 1'b1)
    begin
      fails++;
      $display("MISMATCH t=%0t no bus answer", $time);
      complete_run;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, idx, d, q);
  endtask
  task rd(input logic [5:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    xfer(1'b0, idx, 8'h00, q);
    chk(q, {24'h0, exp});
  endtask
  // ========================================
  // Scenarios
  task s_reset_vals;
    foreach (tbl[i]) rd(tbl[i], 8'h00);
    rd(IOP_IDX_MCU, 8'h00);
    chk({debug_interface_disable_o, vector_table_select_o, vector_change_enable_o}, 3'h0);
    chk(port_oe_o, 48'h0);
    chk(port_in_en_o, 48'hffff_ffff_ffff);
  endtask
  task s_regs;
    foreach (tbl[i]) wr(tbl[i], {2'b10, tbl[i]});
    foreach (tbl[i]) rd(tbl[i], {2'b10, tbl[i]});
    chk({port_oe_o[47:40], port_out_o[47:40], port_oe_o[7:0]}, 24'h909181);
    wr(6'h0f, 8'hff);
    rd(6'h0f, 8'h00);
    wb_sel_i <= 4'h0;
    wr(IOP_IDX_A_OUT, 8'h00);
    wb_sel_i <= 4'h1;
    rd(IOP_IDX_A_OUT, 8'h82);
  endtask
  task s_control;
    wr(IOP_IDX_MCU, 8'hff);
    rd(IOP_IDX_MCU, 8'h93);
    chk({debug_interface_disable_o, vector_table_select_o, vector_change_enable_o}, 3'h7);
    wr(IOP_IDX_MCU, 8'h00);
  endtask
  task s_pins;
    wr(IOP_IDX_A_DIR, 8'hff);
    wr(IOP_IDX_A_OUT, 8'h5a);
    rd(IOP_IDX_A_PIN, 8'h5a);
    wr(IOP_IDX_A_DIR, 8'h0f);
    wr(IOP_IDX_A_OUT, 8'hf0);
    rd(IOP_IDX_A_PIN, 8'hf0);
    chk({port_pullup_o[7:0], portg_pullup_o}, 12'hf0c);
    wr(IOP_IDX_MCU, 8'h10);
    chk({port_pullup_o, portg_pullup_o}, 52'h0);
    wr(IOP_IDX_MCU, 8'h00);
  endtask
  task s_lcd;
    for (int e = 0; e < 2; e++)
      for (int m = 0; m < 8; m++)
      begin
        lcd_driver_enable_i <= e[0];
        lcd_port_mask_i <= m[2:0];
        @(posedge clk_i);
        act = {e == 1 && m > 6, e == 1, {2{e == 1 && m > 0}}};
        chk({portg_oe_o, portg_pullup_o}, {4'h3 & ~act, 4'hc & ~act});
        chk({portg_in_en_o, portg_out_o}, {act ^ 4'hf, 4'hc});
      end
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial
  begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {4'h8, 40'h0};
    {lcd_driver_enable_i, lcd_port_mask_i, wb_sel_i} = 8'h01;
    {portg_dir_i, portg_out_i} = 8'h3c;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_reset_vals;
    s_regs;
    s_control;
    s_pins;
    s_lcd;
    wr(IOP_IDX_MCU, 8'h93);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_reset_vals;
    complete_run;
  end
endmodule
bind iop_port_bank iop_port_bank_asserts iop_port_bank_asserts_i (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .port_out_o, .port_oe_o,
  .port_pullup_o, .lcd_driver_enable_i, .lcd_port_mask_i, .portg_dir_i, .portg_out_i,
  .portg_out_o, .portg_oe_o, .portg_pullup_o, .portg_in_en_o);
